// [core/dwd_decoder.v]
`default_nettype none
`include "dwd_map.vh"
// Serial word decoder for a dual ten-bit DAC. Pins sampled on clk_sys_i.
module dwd_decoder
(
  input  wire       clk_sys_i,
  input  wire       reset_n_i,
  input  wire       cs_n_i,
  input  wire       sclk_i,
  input  wire       din_i,
  output reg  [9:0] channel_a_o,
  output reg  [9:0] channel_b_o,
  output reg  [9:0] staging_o,
  output reg  [1:0] vref_sel_o,
  output reg        vref_internal_o,
  output reg        vref_high_o,
  output reg        settling_fast_o,
  output reg        powerdown_o,
  output reg        update_a_o,
  output reg        update_b_o
);
  wire        cs_n_s;
  wire        sclk_s;
  wire        din_s;
  reg         sclk_q;
  reg         din_q;
  wire [15:0] word;
  wire        word_valid;
  wire [1:0]  target;
  wire [9:0]  value;
  wire [1:0]  next_ref;

  dwd_sync u_cs
  (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .async_i   (cs_n_i),
    .sync_o    (cs_n_s)
  );
  dwd_sync u_sclk
  (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .async_i   (sclk_i),
    .sync_o    (sclk_s)
  );
  dwd_sync u_din
  (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .async_i   (din_i),
    .sync_o    (din_s)
  );

  // Data delayed to line up with the detected clock edge
  always @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      sclk_q <= 1'b0;
      din_q  <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk_s;
      din_q  <= din_s;
    end
  end

  dwd_shifter u_shift
  (
    .clk_sys_i    (clk_sys_i),
    .reset_n_i    (reset_n_i),
    .cs_active_i  (~cs_n_s),
    .sclk_fall_i  (sclk_q & ~sclk_s),
    .sclk_rise_i  (~sclk_q & sclk_s),
    .din_i        (din_q),
    .word_o       (word),
    .word_valid_o (word_valid)
  );

  assign target = {word[`DWD_BIT_SEL_HI], word[`DWD_BIT_SEL_LO]};
  assign value = word[`DWD_VAL_MSB:`DWD_VAL_LSB];
  assign next_ref = word[1:0];

  always @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      channel_a_o     <= 10'h000;
      channel_b_o     <= 10'h000;
      staging_o       <= 10'h000;
      vref_sel_o      <= 2'h0;
      vref_internal_o <= 1'b0;
      vref_high_o     <= 1'b0;
      settling_fast_o <= 1'b0;
      powerdown_o     <= 1'b0;
      update_a_o      <= 1'b0;
      update_b_o      <= 1'b0;
    end
    else
    begin
      update_a_o <= 1'b0;
      update_b_o <= 1'b0;
      if (word_valid)
      begin
        settling_fast_o <= word[`DWD_BIT_SPEED];
        powerdown_o <= word[`DWD_BIT_PWRDN];
        case (target)
          `DWD_TGT_B_BUF:
          begin
            channel_b_o <= value;
            staging_o   <= value;
            update_b_o  <= 1'b1;
          end
          `DWD_TGT_BUF:
            staging_o <= value;
          // A plus transfer; both same edge
          `DWD_TGT_A_XFER:
          begin
            channel_a_o <= value;
            channel_b_o <= staging_o;
            update_a_o  <= 1'b1;
            update_b_o  <= 1'b1;
          end
          `DWD_TGT_CTRL:
          begin
            vref_sel_o <= next_ref;
            vref_internal_o <= (next_ref == `DWD_REF_1V024) ||
                               (next_ref == `DWD_REF_2V048);
            vref_high_o     <= (next_ref == `DWD_REF_2V048);
          end
          default:
            staging_o <= staging_o;
        endcase
      end
    end
  end
endmodule // dwd_decoder
`default_nettype wire

// [core/dwd_map.vh]
// Overview of operation
// - Select 00 loads channel B and buffer
// - Select 01 loads buffer only
// - Select 10 loads A, buffer to B
// - Select 11 writes control register
// - Value is data bits eleven to two
// - Control uses two lowest bits; speed and power bits apply too
// - Codes 00/11 external, 01 low, 10 high
// - Output changes on next rising clock
// - Buffer then transfer updates both together
// - Reference selection kept across channel writes
// - Bit thirteen set forces power down
// - Bit fourteen fast, thirteen zero normal
// - MSB first on falling serial edges
// - Transfer at sixteen bits or select rise
// - Reset clears all latches to zero
`ifndef DWD_MAP_VH
`define DWD_MAP_VH
`define DWD_WORD_BITS 16
`define DWD_BIT_SEL_HI 15
`define DWD_BIT_SPEED 14
`define DWD_BIT_PWRDN 13
`define DWD_BIT_SEL_LO 12
`define DWD_VAL_MSB 11
`define DWD_VAL_LSB 2
`define DWD_TGT_B_BUF 2'b00
`define DWD_TGT_BUF 2'b01
`define DWD_TGT_A_XFER 2'b10
`define DWD_TGT_CTRL 2'b11
`define DWD_REF_EXT 2'b00
`define DWD_REF_1V024 2'b01
`define DWD_REF_2V048 2'b10
`define DWD_REF_EXT_ALT 2'b11
`endif

// [core/dwd_sync.v]
`default_nettype none
module dwd_sync
(
  input  wire clk_sys_i,
  input  wire reset_n_i,
  input  wire async_i,
  output reg  sync_o
);
  reg meta;
  always @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      meta   <= 1'b0;
      sync_o <= 1'b0;
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule // dwd_sync
`default_nettype wire

// [core/dwd_shifter.v]
`default_nettype none
`include "dwd_map.vh"
module dwd_shifter
(
  input  wire        clk_sys_i,
  input  wire        reset_n_i,
  input  wire        cs_active_i,
  input  wire        sclk_fall_i,
  input  wire        sclk_rise_i,
  input  wire        din_i,
  output reg  [15:0] word_o,
  output reg         word_valid_o
);
  reg [15:0] shreg;
  reg [4:0]  count;
  reg        pend;
  reg        cs_q;
  always @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      shreg        <= 16'h0000;
      count        <= 5'h00;
      pend         <= 1'b0;
      cs_q         <= 1'b0;
      word_o       <= 16'h0000;
      word_valid_o <= 1'b0;
    end
    else
    begin
      cs_q         <= cs_active_i;
      word_valid_o <= 1'b0;
      if (cs_active_i && !cs_q)
      begin
        // Fresh frame: short words come out right aligned
        shreg <= 16'h0000;
        count <= 5'h00;
        pend  <= 1'b0;
      end
      else if (cs_active_i && sclk_fall_i && count < 5'h10)
      begin
        shreg <= {shreg[14:0], din_i};
        count <= count + 5'h01;
        if (count == 5'h0f)
        begin
          word_o <= {shreg[14:0], din_i};
          pend   <= 1'b1;
        end
      end
      else if (pend && cs_active_i && sclk_rise_i)
      begin
        pend         <= 1'b0;
        word_valid_o <= 1'b1;
      end
      // select rise completes word
      // A full word already applied on the clock rise is not applied again
      else if (!cs_active_i && cs_q && count != 5'h00 &&
               !(count == 5'h10 && !pend))
      begin
        if (!pend)
          word_o <= shreg;
        pend         <= 1'b0;
        count        <= 5'h00;
        word_valid_o <= 1'b1;
      end
    end
  end
endmodule // dwd_shifter
`default_nettype wire

// [test/dwd_props.sv]
`default_nettype none
module dwd_props
(
  input wire logic       clk_sys_i,
  input wire logic       reset_n_i,
  input wire logic       cs_n_i,
  input wire logic [9:0] channel_a_o,
  input wire logic [9:0] channel_b_o,
  input wire logic [9:0] staging_o,
  input wire logic [1:0] vref_sel_o,
  input wire logic       vref_internal_o,
  input wire logic       vref_high_o,
  input wire logic       update_a_o,
  input wire logic       update_b_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_reset_clear: assert property ($rose(reset_n_i) |->
    {channel_a_o, channel_b_o, staging_o, vref_sel_o} == 32'h0)
    else $error("latches not cleared");
  a_vref_decode: assert property (vref_internal_o == ^vref_sel_o &&
    vref_high_o == (vref_sel_o == 2'b10)) else $error("bad ref decode");
  a_chan_a_pulse: assert property ($changed(channel_a_o) |-> update_a_o)
    else $error("a moved without pulse");
  a_chan_b_pulse: assert property ($changed(channel_b_o) |-> update_b_o)
    else $error("b moved without pulse");
  a_pulse_single: assert property (update_b_o |=> !update_b_o)
    else $error("long pulse");
  a_xfer_both: assert property (update_a_o |-> update_b_o)
    else $error("a without b");
  a_b_copies_buffer: assert property (update_b_o |->
    channel_b_o == staging_o) else $error("b differs from buffer");
  a_ref_kept: assert property (update_b_o |-> $stable(vref_sel_o))
    else $error("ref moved");
  a_idle_quiet: assert property (cs_n_i [*8] |=> $stable(staging_o))
    else $error("write while idle");
endmodule // dwd_props
bind dwd_decoder dwd_props u_props (.clk_sys_i, .reset_n_i, .cs_n_i,
  .channel_a_o, .channel_b_o, .staging_o, .vref_sel_o, .vref_internal_o,
  .vref_high_o, .update_a_o, .update_b_o);
`default_nettype wire

// [test/dwd_host.sv]
`default_nettype none
module dwd_host
(
  input  wire logic clk_sys_i,
  output var  logic cs_n_o,
  output var  logic sclk_o,
  output var  logic din_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    din_o = 1'b0;
  end
  // Half of a 160 ns serial period
  task automatic half();
    repeat (10) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic send(input logic [15:0] w, input int n);
    cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      din_o = w[i];
      half();
      sclk_o = 1'b0;
      half();
      sclk_o = 1'b1;
    end
    half();
    cs_n_o = 1'b1;
    // Released line must not hold last bit
    din_o = ~din_o;
    half();
  endtask
endmodule // dwd_host
`default_nettype wire

// [test/test_dwd_decoder.sv]
`default_nettype none
module test_dwd_decoder;
  timeunit 1ns;
  timeprecision 100ps;
  logic            clk_sys_i;
  logic            reset_n_i;
  wire logic       cs_n_i, sclk_i, din_i;
  wire logic [9:0] channel_a_o, channel_b_o, staging_o;
  wire logic [1:0] vref_sel_o;
  wire logic       vref_internal_o, vref_high_o, settling_fast_o;
  wire logic       powerdown_o, update_a_o, update_b_o;
  int              fail_count = 0;
  int              tests_run = 0;
  dwd_decoder dut (.*);
  dwd_host host (.clk_sys_i, .cs_n_o(cs_n_i), .sclk_o(sclk_i), .din_o(din_i));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      $display("Error %0t got %h want %h", $time, g, e);
      fail_count++;
    end
  endtask
  task automatic t_ctrl();
    for (int c = 0; c < 4; c++)
    begin
      // external codes 00 and 11 kept for outside supply
      host.send({4'b1101, 10'h3ff, c[1:0]}, 16);
      chk(vref_sel_o, c[1:0]);
      chk({vref_internal_o, vref_high_o}, {c[0] ^ c[1], c == 2});
      chk({settling_fast_o, channel_a_o}, {1'b1, 10'h0});
    end
  endtask
  task automatic t_route();
    host.send({4'b0000, 10'h2a5, 2'b00}, 16);
    chk({channel_b_o, staging_o}, {10'h2a5, 10'h2a5});
    host.send({4'b0001, 10'h15a, 2'b00}, 16);
    chk({channel_b_o, staging_o}, {10'h2a5, 10'h15a});
    host.send({4'b1000, 10'h3c3, 2'b00}, 16);
    chk({channel_a_o, channel_b_o}, {10'h3c3, 10'h15a});
    chk({vref_sel_o, settling_fast_o}, {2'b11, 1'b0});
  endtask
  task automatic t_pwr();
    host.send(16'hf000, 16);
    chk(powerdown_o, 1'b1);
    host.send(16'h4004, 16);
    chk({powerdown_o, channel_b_o}, {1'b0, 10'h001});
  endtask
  task automatic t_short();
    host.send(16'h00fc, 8);
    chk(channel_b_o, 10'h03f);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    reset_n_i = 1'b0;
    repeat (12) @(posedge clk_sys_i);
    #1 reset_n_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk({channel_a_o, channel_b_o, staging_o}, 32'h0);
    t_ctrl();
    t_route();
    t_pwr();
    t_short();
    test_done();
  end
endmodule // test_dwd_decoder
`default_nettype wire
